// ### aes_pkg.sv
// Constants shared by the AES engine: register map, field positions, timing.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
package aes_pkg;

	// Register byte offsets, one aligned word each
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_STATE  = 8'h08;
	localparam logic [7:0] REG_KEY    = 8'h0c;
	localparam logic [7:0] REG_MASK   = 8'h10;

	// Control fields
	localparam int CTRL_START   = 0;
	localparam int CTRL_DECRYPT = 1;
	localparam int CTRL_AUTO    = 2;
	localparam int CTRL_XOR     = 3;

	// Status and mask fields
	localparam int STAT_DONE = 0;
	localparam int STAT_BUSY = 1;

	// Reset values
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic       MASK_RESET = 1'b0;

	// Run length in peripheral clocks (375)
	localparam logic [8:0] RUN_CYCLES = 9'h177;
	localparam logic [8:0] CNT_FIRST  = 9'h001;

	// Block geometry
	localparam logic [3:0] NUM_ROUNDS = 4'ha;
	localparam logic [3:0] FIRST_RND  = 4'h1;
	localparam logic [3:0] LAST_BYTE  = 4'hf;

	// Field arithmetic
	localparam logic [7:0] GF_POLY   = 8'h1b;
	localparam logic [7:0] AFF_C     = 8'h63;
	localparam logic [7:0] AFF_INV_C = 8'h05;

	typedef enum logic [1:0] {ST_IDLE, ST_EXPAND, ST_ROUND, ST_HOLD} aes_state_e;

endpackage

// ### aes_engine.sv
// AES-128 block engine with a classic Wishbone register slave.
// Assumes one clock MCLK, a single-master bus, and byte-wide use of the data ports.
//
// Function
// - One 128-bit block is encrypted or decrypted with a 128-bit key per the standard cipher.
// - A run completes exactly 375 clocks after its start and only then is the result readable.
// - Completion raises the interrupt only while the completion interrupt is enabled.
// - Each completion pulses a trigger toward the DMA controller.
// - With auto-start set, writing the last state byte starts a run without a command.
// - In XOR load mode each written state byte is XORed into the byte already stored.
// - State storage is 16 bytes, loaded and read out by sixteen byte accesses.
//
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module aes_engine
	import aes_pkg::*;
(
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	input  wire logic        WE_I,
	input  wire logic [7:0]  ADR_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic [31:0] DAT_I,
	output logic      [31:0] DAT_O,
	output logic             ACK_O,
	output logic             IRQ,
	output logic             DMA_TRIG
);

	// Field helpers
	function automatic logic [7:0] xt(input logic [7:0] a);
		return {a[6:0], 1'b0} ^ (a[7] ? GF_POLY : 8'h00);
	endfunction
	function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = 8'h00;
		x = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i])
				p = p ^ x;
			x = xt(x);
		end
		return p;
	endfunction
	// Inverse as a^254, zero maps to zero
	function automatic logic [7:0] ginv(input logic [7:0] a);
		logic [7:0] r;
		logic [7:0] s;
		r = 8'h01;
		s = a;
		for (int k = 1; k < 8; k++) begin
			s = gmul(s, s);
			r = gmul(r, s);
		end
		return r;
	endfunction

	function automatic logic [7:0] rl(input logic [7:0] b, input int n);
		logic [15:0] d;
		d = {b, b};
		return d[15-n -: 8];
	endfunction
	// S-boxes computed instead of tabled, trading depth for area
	function automatic logic [7:0] sbox(input logic [7:0] b);
		logic [7:0] v;
		v = ginv(b);
		return v ^ rl(v, 1) ^ rl(v, 2) ^ rl(v, 3) ^ rl(v, 4) ^ AFF_C;
	endfunction
	function automatic logic [7:0] isbox(input logic [7:0] b);
		return ginv(rl(b, 1) ^ rl(b, 3) ^ rl(b, 6) ^ AFF_INV_C);
	endfunction
	function automatic logic [127:0] sub_all(input logic [127:0] s, input logic inv);
		logic [127:0] o;
		o = '0;
		for (int i = 0; i < 16; i++)
			o[8*i +: 8] = inv ? isbox(s[8*i +: 8]) : sbox(s[8*i +: 8]);
		return o;
	endfunction

	// Byte i is row i%4 of column i/4
	function automatic logic [127:0] shift(input logic [127:0] s, input logic inv);
		logic [127:0] o;
		int src;
		o = '0;
		for (int c = 0; c < 4; c++) begin
			for (int r = 0; r < 4; r++) begin
				src = inv ? ((c - r) & 3) : ((c + r) & 3);
				o[8*(4*c+r) +: 8] = s[8*(4*src+r) +: 8];
			end
		end
		return o;
	endfunction

	function automatic logic [127:0] mix(input logic [127:0] s, input logic inv);
		logic [127:0] o;
		logic [7:0]   m [4];
		logic [7:0]   acc;
		o = '0;
		m[0] = inv ? 8'h0e : 8'h02;
		m[1] = inv ? 8'h0b : 8'h03;
		m[2] = inv ? 8'h0d : 8'h01;
		m[3] = inv ? 8'h09 : 8'h01;
		for (int c = 0; c < 4; c++) begin
			for (int r = 0; r < 4; r++) begin
				acc = 8'h00;
				for (int j = 0; j < 4; j++)
					acc = acc ^ gmul(s[8*(4*c+((r+j)&3)) +: 8], m[j]);
				o[8*(4*c+r) +: 8] = acc;
			end
		end
		return o;
	endfunction

	function automatic logic [7:0] rcon(input logic [3:0] n);
		logic [7:0] r;
		r = 8'h01;
		for (int i = 1; i < 10; i++)
			if (i < n)
				r = xt(r);
		return r;
	endfunction
	// RotWord, SubWord and round constant on one key word
	function automatic logic [31:0] kt(input logic [31:0] w, input logic [7:0] rc);
		return {sbox(w[7:0]), sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]) ^ rc};
	endfunction
	function automatic logic [127:0] knext(input logic [127:0] k, input logic [7:0] rc);
		logic [31:0] n0;
		logic [31:0] n1;
		logic [31:0] n2;
		n0 = k[31:0] ^ kt(k[127:96], rc);
		n1 = k[63:32] ^ n0;
		n2 = k[95:64] ^ n1;
		return {k[127:96] ^ n2, n2, n1, n0};
	endfunction
	// Walks the schedule backward so decryption needs no stored key set
	function automatic logic [127:0] kprev(input logic [127:0] k, input logic [7:0] rc);
		logic [31:0] p3;
		p3 = k[127:96] ^ k[95:64];
		return {p3, k[95:64] ^ k[63:32], k[63:32] ^ k[31:0], k[31:0] ^ kt(p3, rc)};
	endfunction
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return {a[7:2], 2'b00} == off;
	endfunction

	logic         ack_q;
	logic [31:0]  dat_q;
	logic [2:0]   mode_q;
	logic         mask_q;
	logic         done_q;
	logic         dma_q;
	logic [127:0] state_q;
	logic [127:0] key_q;
	logic [127:0] rk_q;
	logic [3:0]   st_ptr_q;
	logic [3:0]   key_ptr_q;
	logic [3:0]   rnd_q;
	logic [8:0]   cnt_q;
	aes_state_e   eng_q;
	logic         req;
	logic         wr;
	logic         rd;
	logic         busy;
	logic         dec;
	logic         st_wr;
	logic         st_rd;
	logic         key_wr;
	logic         go;
	logic         fin;
	logic [127:0] ld_v;
	logic [127:0] k_fwd;
	logic [127:0] k_bwd;
	logic [127:0] enc_v;
	logic [127:0] dec_v;
	logic [7:0]   rc;

	// Bus qualifiers; effects occur on the edge that raises ack
	assign req    = CYC_I & STB_I & ~ack_q;
	assign wr     = req & WE_I & SEL_I[0];
	assign rd     = req & ~WE_I;
	assign busy   = eng_q != ST_IDLE;
	assign dec    = (wr & hit(ADR_I, REG_CTRL) & ~busy) ? DAT_I[CTRL_DECRYPT]
	              : mode_q[CTRL_DECRYPT-1]; // A start by CTRL write uses the direction it writes
	assign st_wr  = wr & hit(ADR_I, REG_STATE) & ~busy;
	assign st_rd  = rd & hit(ADR_I, REG_STATE) & ~busy;
	assign key_wr = wr & hit(ADR_I, REG_KEY) & ~busy;
	assign go     = (wr & hit(ADR_I, REG_CTRL) & DAT_I[CTRL_START] & ~busy)
	              | (st_wr & mode_q[CTRL_AUTO-1] & (st_ptr_q == LAST_BYTE));
	assign fin    = busy & (cnt_q == RUN_CYCLES);

	// Incoming state byte, replaced or XORed in; a CTRL start leaves the block as is
	always_comb begin
		ld_v = state_q;
		if (st_wr & mode_q[CTRL_XOR-1])
			ld_v[8*st_ptr_q +: 8] = state_q[8*st_ptr_q +: 8] ^ DAT_I[7:0];
		else if (st_wr)
			ld_v[8*st_ptr_q +: 8] = DAT_I[7:0];
	end

	// One full round per clock in either direction
	always_comb begin
		rc    = rcon(rnd_q);
		k_fwd = knext(rk_q, rc);
		k_bwd = kprev(rk_q, rc);
		enc_v = shift(sub_all(state_q, 1'b0), 1'b0);
		if (rnd_q != NUM_ROUNDS)
			enc_v = mix(enc_v, 1'b0);
		enc_v = enc_v ^ k_fwd;
		dec_v = sub_all(shift(state_q, 1'b1), 1'b1) ^ k_bwd;
		if (rnd_q != FIRST_RND)
			dec_v = mix(dec_v, 1'b1);
	end

	// Bus acknowledge, every access answered one cycle later
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N)
			ack_q <= 1'b0;
		else
			ack_q <= req;
	end

	// Read data; unmapped and key reads give zero so the key never leaks
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			dat_q <= 32'h0;
		end else if (rd) begin
			dat_q <= 32'h0;
			if (hit(ADR_I, REG_CTRL))
				dat_q[CTRL_XOR:CTRL_DECRYPT] <= mode_q;
			else if (hit(ADR_I, REG_STATUS))
				dat_q[STAT_BUSY:STAT_DONE] <= {busy, done_q};
			else if (hit(ADR_I, REG_MASK))
				dat_q[STAT_DONE] <= mask_q;
			else if (st_rd)
				dat_q[7:0] <= state_q[8*st_ptr_q +: 8];
		end
	end

	// Mode bits frozen during a run so the direction cannot change mid-block
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N)
			mode_q <= MODE_RESET;
		else if (wr & hit(ADR_I, REG_CTRL) & ~busy)
			mode_q <= DAT_I[CTRL_XOR:CTRL_DECRYPT];
	end

	// Interrupt mask
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N)
			mask_q <= MASK_RESET;
		else if (wr & hit(ADR_I, REG_MASK))
			mask_q <= DAT_I[STAT_DONE];
	end

	// Done flag: completion beats a clearing status read in the same cycle
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N)
			done_q <= 1'b0;
		else if (fin)
			done_q <= 1'b1;
		else if (go | (rd & hit(ADR_I, REG_STATUS)))
			done_q <= 1'b0;
	end

	// DMA trigger, one clock at completion
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N)
			dma_q <= 1'b0;
		else
			dma_q <= fin;
	end

	// Byte pointers; both restart at a run start, state also at completion
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			st_ptr_q  <= 4'h0;
			key_ptr_q <= 4'h0;
		end else begin
			if (go | fin)
				st_ptr_q <= 4'h0;
			else if (st_wr | st_rd)
				st_ptr_q <= st_ptr_q + 4'h1;
			if (go)
				key_ptr_q <= 4'h0;
			else if (key_wr)
				key_ptr_q <= key_ptr_q + 4'h1;
		end
	end

	// Key storage, bus side only
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N)
			key_q <= '0;
		else if (key_wr)
			key_q[8*key_ptr_q +: 8] <= DAT_I[7:0];
	end

	// State storage, shared between bus loads and the rounds
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N)
			state_q <= '0;
		else if (go)
			state_q <= dec ? ld_v : (ld_v ^ key_q);
		else if (eng_q == ST_EXPAND && rnd_q == NUM_ROUNDS)
			state_q <= state_q ^ k_fwd;
		else if (eng_q == ST_ROUND)
			state_q <= dec ? dec_v : enc_v;
		else if (st_wr)
			state_q <= ld_v;
	end

	// Sequencer: rounds finish early, then hold until the fixed count ends
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			eng_q <= ST_IDLE;
			rnd_q <= FIRST_RND;
			cnt_q <= CNT_FIRST;
			rk_q  <= '0;
		end else begin
			unique case (eng_q)
				ST_IDLE: begin
					if (go) begin
						cnt_q <= CNT_FIRST;
						rk_q  <= key_q;
						rnd_q <= FIRST_RND;
						eng_q <= dec ? ST_EXPAND : ST_ROUND;
					end
				end
				ST_EXPAND: begin
					rk_q <= k_fwd;
					if (rnd_q == NUM_ROUNDS)
						eng_q <= ST_ROUND;
					else
						rnd_q <= rnd_q + 4'h1;
				end
				ST_ROUND: begin
					if (dec) begin
						rk_q  <= k_bwd;
						rnd_q <= rnd_q - 4'h1;
						if (rnd_q == FIRST_RND)
							eng_q <= ST_HOLD;
					end else begin
						rk_q  <= k_fwd;
						rnd_q <= rnd_q + 4'h1;
						if (rnd_q == NUM_ROUNDS)
							eng_q <= ST_HOLD;
					end
				end
				ST_HOLD: begin
				end
			endcase
			if (busy) begin
				if (fin)
					eng_q <= ST_IDLE;
				else
					cnt_q <= cnt_q + 9'h001;
			end
		end
	end

	assign DAT_O    = dat_q;
	assign ACK_O    = ack_q;
	assign IRQ      = done_q & mask_q;
	assign DMA_TRIG = dma_q;

endmodule

// ### aes_engine_props.sv
// Port checker for the AES engine: bus answer, run timing, interrupt and trigger.
// Assumes SEL_I[0] is set on every access, as the bench does.
`timescale 1ns/1ps
module aes_engine_props
	import aes_pkg::*;
(
	input wire logic        MCLK,
	input wire logic        RST_N,
	input wire logic        CYC_I,
	input wire logic        STB_I,
	input wire logic        WE_I,
	input wire logic [7:0]  ADR_I,
	input wire logic [3:0]  SEL_I,
	input wire logic [31:0] DAT_I,
	input wire logic [31:0] DAT_O,
	input wire logic        ACK_O,
	input wire logic        IRQ,
	input wire logic        DMA_TRIG
);
	logic       take, wr_ctl, go, idle, st_acc, auto_q, mask_q;
	logic [8:0] cnt_q;
	logic [3:0] ptr_q;
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	// Accepted access and the starts it causes
	assign take   = CYC_I && STB_I && !ACK_O;
	assign idle   = cnt_q == 9'h000;
	assign st_acc = take && ADR_I[7:2] == REG_STATE[7:2] && idle;
	assign wr_ctl = take && WE_I && SEL_I[0] && ADR_I[7:2] == REG_CTRL[7:2] && idle;
	assign go     = wr_ctl && DAT_I[CTRL_START] || st_acc && WE_I && auto_q && ptr_q == LAST_BYTE;
	// Shadow run counter; it only knows starts taken while idle
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) cnt_q <= 9'h000;
		else if (go) cnt_q <= CNT_FIRST;
		else if (cnt_q == RUN_CYCLES) cnt_q <= 9'h000;
		else if (!idle) cnt_q <= cnt_q + CNT_FIRST;
	end
	// Shadow state pointer, cleared by start and completion
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) ptr_q <= 4'h0;
		else if (go || cnt_q == RUN_CYCLES) ptr_q <= 4'h0;
		else if (st_acc) ptr_q <= ptr_q + 4'h1;
	end
	// Shadow mode and mask bits
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			auto_q <= 1'b0;
			mask_q <= 1'b0;
		end else begin
			if (wr_ctl) auto_q <= DAT_I[CTRL_AUTO];
			if (take && WE_I && ADR_I[7:2] == REG_MASK[7:2]) mask_q <= DAT_I[0];
		end
	end
	sequence s_pulse;
		DMA_TRIG ##1 !DMA_TRIG;
	endsequence
	property p_ack; take |=> ACK_O; endproperty
	property p_trig; DMA_TRIG == ($past(cnt_q) == RUN_CYCLES); endproperty
	property p_pulse; $past(cnt_q) == RUN_CYCLES |-> s_pulse; endproperty
	property p_irq_mask; !mask_q |-> !IRQ; endproperty
	property p_irq_done; DMA_TRIG && mask_q |-> IRQ; endproperty
	property p_irq_rise;
		$rose(IRQ) |-> DMA_TRIG || $past(take && WE_I && ADR_I[7:2] == REG_MASK[7:2]);
	endproperty
	property p_stat_clr;
		take && !WE_I && ADR_I[7:2] == REG_STATUS[7:2] && cnt_q != RUN_CYCLES |=> !IRQ;
	endproperty
	property p_busy;
		take && !WE_I && ADR_I[7:2] == REG_STATUS[7:2] |=> DAT_O[STAT_BUSY] == $past(!idle);
	endproperty
	property p_blank;
		take && !WE_I && (ADR_I[7:2] == REG_STATE[7:2] && !idle && cnt_q != RUN_CYCLES
			|| ADR_I[7:2] == REG_KEY[7:2]) |=> DAT_O == 32'h00000000;
	endproperty
	a_ack: assert property (p_ack) else $error("no ack after access");
	a_trig: assert property (p_trig) else $error("trigger off run end");
	a_pulse: assert property (p_pulse) else $error("trigger not one cycle");
	a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
	a_irq_done: assert property (p_irq_done) else $error("irq missing at end");
	a_irq_rise: assert property (p_irq_rise) else $error("irq rose alone");
	a_stat_clr: assert property (p_stat_clr) else $error("done not cleared");
	a_busy: assert property (p_busy) else $error("busy bit wrong");
	a_blank: assert property (p_blank) else $error("blocked read not zero");
endmodule
bind aes_engine aes_engine_props u_props (.MCLK(MCLK), .RST_N(RST_N), .CYC_I(CYC_I),
	.STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O),
	.ACK_O(ACK_O), .IRQ(IRQ), .DMA_TRIG(DMA_TRIG));

// ### aes_bus_master.sv
// Classic Wishbone master standing in for the processor or DMA side.
// Assumes a slave that answers within 63 cycles; a slower one sets hang.
`timescale 1ns/1ps
module aes_bus_master (
	input  wire logic        mclk,
	input  wire logic        ack,
	input  wire logic [31:0] rdat,
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic [7:0]       adr,
	output logic [3:0]       sel,
	output logic [31:0]      wdat
);
	logic hang;
	// Idle bus from time zero; byte lane 0 only
	initial begin
		{cyc, stb, we, hang} = 4'h0;
		adr = 8'h00;
		sel = 4'h1;
		wdat = 32'h00000000;
	end
	// One single cycle; waiting an edge first keeps the bus low between cycles
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
			output logic [7:0] q);
		int n;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 64);
		hang = n >= 64;
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
endmodule

// ### aes_engine_bench.sv
// Self-checking bench for the AES engine: known vectors, XOR load, auto-start.
// Assumes the bus master model and the bound port checker.
`timescale 1ns/1ps
module aes_engine_bench
	import aes_pkg::*;
;
	localparam logic [127:0] KEY = 128'h000102030405060708090a0b0c0d0e0f;
	localparam logic [127:0] PT  = 128'h00112233445566778899aabbccddeeff;
	localparam logic [127:0] CT  = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
	logic         mclk, rst_n, cyc, stb, we, ack, irq, trig;
	logic [7:0]   adr, rd;
	logic [3:0]   sel;
	logic [31:0]  dat_i, dat_o;
	logic [127:0] r;
	int           n_mismatch, checks_done, n;
	aes_engine DUT (.MCLK(mclk), .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
		.ADR_I(adr), .SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack), .IRQ(irq),
		.DMA_TRIG(trig));
	aes_bus_master m (.mclk(mclk), .ack(ack), .rdat(dat_o), .cyc(cyc), .stb(stb), .we(we),
		.adr(adr), .sel(sel), .wdat(dat_i));
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Bus access; a hung slave ends the run
	task automatic rw(input logic w, input logic [7:0] a, input logic [7:0] d);
		m.xfer(w, a, d, rd);
		if (m.hang) begin
			n_mismatch++;
			close_out();
		end
	endtask
	// Byte i of a block, byte 0 being the first cipher input byte
	function automatic logic [7:0] bt(input logic [127:0] v, input int i);
		return v[127 - 8 * i -: 8];
	endfunction
	task automatic load(input logic [7:0] a, input logic [127:0] v);
		for (int i = 0; i < 16; i++) rw(1'b1, a, bt(v, i));
	endtask
	task automatic readout(input logic [127:0] v);
		for (int i = 0; i < 16; i++) begin
			rw(1'b0, REG_STATE, 8'h00);
			chk("state byte", {8'h00, rd}, {8'h00, bt(v, i)});
		end
	endtask
	// Counts cycles from the start acknowledge to the trigger
	task automatic wait_trig();
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (trig !== 1'b1 && n < 1000);
		if (n >= 1000) begin
			n_mismatch++;
			close_out();
		end
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		rst_n = 1'b0;
		void'($urandom(32'h20ea));
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		rw(1'b0, REG_CTRL, 8'h00);
		chk("ctrl reset", {8'h00, rd}, {12'h000, MODE_RESET, 1'b0});
		rw(1'b0, REG_MASK, 8'h00);
		chk("mask reset", {8'h00, rd}, {15'h0000, MASK_RESET});
		// Encrypt with the interrupt enabled; blocked key read before the start, blocked state read while busy
		rw(1'b1, REG_MASK, 8'h01);
		load(REG_KEY, KEY);
		rw(1'b0, REG_KEY, 8'h00);
		chk("key read", {8'h00, rd}, 16'h0000);
		load(REG_STATE, PT);
		rw(1'b1, REG_CTRL, 8'h01);
		rw(1'b0, REG_STATUS, 8'h00);
		chk("status busy", {8'h00, rd}, 16'h0002);
		rw(1'b0, REG_STATE, 8'h00);
		chk("busy read", {8'h00, rd}, 16'h0000);
		wait_trig();
		chk("irq on", {15'h0000, irq}, 16'h0001);
		rw(1'b0, REG_STATUS, 8'h00);
		chk("status done", {8'h00, rd}, 16'h0001);
		chk("irq cleared", {15'h0000, irq}, 16'h0000);
		readout(CT);
		// Decrypt with the interrupt masked, run length counted
		rw(1'b1, REG_MASK, 8'h00);
		load(REG_STATE, CT);
		rw(1'b1, REG_CTRL, 8'h03);
		wait_trig();
		chk("run length", n[15:0], 16'h0177);
		chk("irq masked", {15'h0000, irq}, 16'h0000);
		readout(PT);
		// Random block folded into the plaintext by XOR load
		r = {$urandom, $urandom, $urandom, $urandom};
		load(REG_STATE, r);
		rw(1'b1, REG_CTRL, 8'h08);
		load(REG_STATE, r ^ PT);
		rw(1'b1, REG_CTRL, 8'h01);
		wait_trig();
		readout(CT);
		// Auto-start on the sixteenth state byte
		rw(1'b1, REG_CTRL, 8'h04);
		load(REG_STATE, PT);
		wait_trig();
		chk("auto run length", n[15:0], 16'h0177);
		readout(CT);
		// Reset in the middle of a run leaves no result and no trigger behind
		rw(1'b1, REG_CTRL, 8'h01);
		repeat (20) @(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rw(1'b0, REG_STATUS, 8'h00);
		chk("status after reset", {8'h00, rd}, 16'h0000);
		chk("trigger after reset", {15'h0000, trig}, 16'h0000);
		chk("irq after reset", {15'h0000, irq}, 16'h0000);
		close_out();
	end
endmodule
